// >>> cds_params.svh
`ifndef CDS_PARAMS_SVH
`define CDS_PARAMS_SVH

// register byte offsets
`define CDS_OFS_MODE     8'h00
`define CDS_OFS_NETCFG   8'h04
`define CDS_OFS_KSPD     8'h08
`define CDS_OFS_DPARAM   8'h0c
`define CDS_OFS_STATUS   8'h10
`define CDS_OFS_NETCMD   8'h14

// reset values
`define CDS_RST_MODE     3'h0
`define CDS_RST_NETCFG   4'h8
`define CDS_RST_KSPD     16'h0000
`define CDS_RST_DPARAM   32'h0000_0000

// net config field positions
`define CDS_NC_SPD       0
`define CDS_NC_START     1
`define CDS_NC_STARTUP   2
`define CDS_NC_STOPALL   3

// status field positions
`define CDS_ST_RUN       4
`define CDS_ST_REV       5
`define CDS_ST_HALT      6
`define CDS_ST_REJ       7

// mode-select parameter values
`define CDS_MS_TOGGLE    3'h0
`define CDS_MS_KEYPAD    3'h1
`define CDS_MS_TERM      3'h2
`define CDS_MS_COMB1     3'h3
`define CDS_MS_COMB2     3'h4
`define CDS_MS_SW6       3'h6
`define CDS_MS_SW7       3'h7

// network mode-change targets
`define CDS_REQ_TERM     2'h0
`define CDS_REQ_KEYPAD   2'h1
`define CDS_REQ_NET      2'h2

// number of network links
`define CDS_NET_LINKS    3

`endif

// >>> cds_pkg.sv
package cds_pkg;
    // operation mode state
    typedef enum logic [2:0] {
        MD_TERMINAL, MD_KEYPAD, MD_NETWORK, MD_COMB1, MD_COMB2
    } cds_mode_t;

    // control terminal bits
    typedef struct packed {
        logic       fwd_start_in;
        logic       rev_start_in;
        logic       jog_in;
        logic [3:0] preset_speed_inputs;
        logic       current_input_enable;
        logic       loop_control_enable;
    } cds_term_t;

    // terminal-side speed values
    typedef struct packed {
        logic [15:0] analog_v;
        logic [15:0] analog_i;
        logic [15:0] loop;
        logic [15:0] preset;
        logic [15:0] jog;
    } cds_tspd_t;

    // keypad and handheld keys, one-cycle pulses
    typedef struct packed {
        logic mode_toggle_key;
        logic run_key;
        logic fwd_key;
        logic rev_key;
        logic stop_key;
    } cds_key_t;

    // one network message
    typedef struct packed {
        logic        valid;
        logic        run;
        logic        rev;
        logic [15:0] speed;
        logic        mode_req;
        logic [1:0]  mode_to;
    } cds_net_t;

    // drive command
    typedef struct packed {
        logic        run;
        logic        rev;
        logic [15:0] speed;
    } cds_cmd_t;
endpackage

// >>> cds_cfg_reg.sv
module cds_cfg_reg #(
    parameter int          W       = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // write port
    input  wire logic         we,
    input  wire logic [W-1:0] d,
    // stored value
    output logic      [W-1:0] q
);
    logic [W-1:0] q_next;

    // load on write
    always_comb begin
        q_next = q;
        if (we) begin
            q_next = d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= RST_VAL;
        end else begin
            q <= q_next;
        end
    end
endmodule // cds_cfg_reg

// >>> cds_ahb_slv.sv
module cds_ahb_slv (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // ahb-lite slave side
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // register file side
    output logic             wr_en,
    output logic      [7:0]  reg_addr,
    output logic      [31:0] wr_data,
    input  wire logic [31:0] rd_data
);
    logic        take;
    logic        wr_pend_reg, wr_pend_next;
    logic        rd_pend_reg, rd_pend_next;
    logic        rd_done_reg, rd_done_next;
    logic        ok_reg, ok_next;
    logic [7:0]  addr_reg, addr_next;
    logic [31:0] hrdata_next;

    // address phase accept; only word accesses are mapped
    assign take = hsel & htrans[1] & hready;

    always_comb begin
        wr_pend_next = take & hwrite;
        rd_pend_next = take ? ~hwrite : (rd_pend_reg & ~rd_done_reg);
        rd_done_next = take ? 1'b0 : (rd_pend_reg & ~rd_done_reg);
        addr_next    = take ? haddr[7:0] : addr_reg;
        ok_next      = take ? ((haddr[31:8] == 24'h0) &&
                               (haddr[1:0] == 2'h0) &&
                               (hsize == 3'h2)) : ok_reg;
        hrdata_next  = hrdata;
        if (rd_pend_reg && !rd_done_reg) begin
            hrdata_next = ok_reg ? rd_data : 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            rd_done_reg <= 1'b0;
            ok_reg      <= 1'b0;
            addr_reg    <= 8'h0;
            hrdata      <= 32'h0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            rd_done_reg <= rd_done_next;
            ok_reg      <= ok_next;
            addr_reg    <= addr_next;
            hrdata      <= hrdata_next;
        end
    end

    // reads take one wait state, writes none
    assign hreadyout = ~(rd_pend_reg & ~rd_done_reg);
    assign hresp     = 1'b0;
    assign wr_en     = wr_pend_reg & ok_reg;
    assign reg_addr  = addr_reg;
    assign wr_data   = hwdata;
endmodule // cds_ahb_slv

// >>> cds_cmd_select.sv
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`include "cds_params.svh"

// Notes on behaviour
// - mode-select 0 or 2 starts in terminal mode at power-on.
// - mode-select 2 locks terminal mode; only network switch still allowed.
// - mode-select 0 toggles terminal and keypad mode on toggle key.
// - terminal mode: run from start inputs, speed from analog/preset/jog.
// - terminal mode rejects writes to protected parameters.
// - mode-select 3: run from start inputs, speed digital keypad value.
// - mode-select 4: run from keypad keys, speed from terminal inputs.
// - mode-select 1 locks keypad mode for run and speed.
// - network, speed source 1: terminal run, network speed.
// - network, start source 1: network run, terminal speed.
// - startup 1 without redirection: run and speed from network.
// - stop key halts drive in every mode by default.
// - mode changes come from keypad or network instruction.
// - network commands via serial, ethernet or option link.
// - mode-select accepts 0-4, 6, 7 only; defaults to 0.
// - mode 3 speed priority: preset, loop, current input, keypad.
module cds_cmd_select (
    // clock and reset
    input  wire logic                MCLK,
    input  wire logic                RST,
    // ahb-lite register bus
    input  wire logic                HSEL,
    input  wire logic [31:0]         HADDR,
    input  wire logic [1:0]          HTRANS,
    input  wire logic                HWRITE,
    input  wire logic [2:0]          HSIZE,
    input  wire logic [31:0]         HWDATA,
    input  wire logic                HREADY,
    output logic      [31:0]         HRDATA,
    output logic                     HREADYOUT,
    output logic                     HRESP,
    // control terminals and keypad
    input  cds_pkg::cds_term_t       TERM,
    input  cds_pkg::cds_tspd_t       TSPD,
    input  cds_pkg::cds_key_t        KEYS,
    // network links: 0 serial, 1 ethernet, 2 option
    input  cds_pkg::cds_net_t        NET_MSG [`CDS_NET_LINKS],
    // drive command and active mode
    output cds_pkg::cds_cmd_t        CMD,
    output cds_pkg::cds_mode_t       MODE
);
    import cds_pkg::*;

    logic        wr_en;
    logic [7:0]  reg_addr;
    logic [31:0] wr_data;
    logic [31:0] rd_data;
    logic [2:0]  mode_sel;
    logic [3:0]  net_cfg;
    logic [15:0] kp_speed;
    logic [31:0] drive_param;
    logic        mode_we, cfg_we, kspd_we, dpar_we;
    logic        mode_legal, dpar_hit;
    logic        rej_reg, rej_next;
    cds_mode_t   mode_reg, mode_next;
    cds_cmd_t    net_reg, net_next;
    cds_cmd_t    cmd_next;
    logic        req_v;
    logic [1:0]  req_to;
    logic        kp_run_reg, kp_run_next;
    logic        kp_rev_reg, kp_rev_next;
    logic        halt_reg, halt_next;
    logic        term_run, term_rev;
    logic [15:0] term_spd, comb1_spd;
    logic        src_run, src_rev;
    logic [15:0] src_spd;

    // bus front end
    cds_ahb_slv u_bus (
        .clk       (MCLK),
        .rst       (RST),
        .hsel      (HSEL),
        .haddr     (HADDR),
        .htrans    (HTRANS),
        .hwrite    (HWRITE),
        .hsize     (HSIZE),
        .hwdata    (HWDATA),
        .hready    (HREADY),
        .hrdata    (HRDATA),
        .hreadyout (HREADYOUT),
        .hresp     (HRESP),
        .wr_en     (wr_en),
        .reg_addr  (reg_addr),
        .wr_data   (wr_data),
        .rd_data   (rd_data)
    );

    // write decode and legality
    always_comb begin
        mode_legal = (wr_data[31:3] == 29'h0) &&
                     (wr_data[2:0] != 3'h5);
        mode_we = wr_en && (reg_addr == `CDS_OFS_MODE) && mode_legal;
        cfg_we  = wr_en && (reg_addr == `CDS_OFS_NETCFG);
        kspd_we = wr_en && (reg_addr == `CDS_OFS_KSPD);
        dpar_hit = wr_en && (reg_addr == `CDS_OFS_DPARAM);
        dpar_we = dpar_hit && (mode_reg != MD_TERMINAL);
    end

    // configuration registers
    cds_cfg_reg #(.W(3), .RST_VAL(`CDS_RST_MODE)) u_mode (
        .clk (MCLK), .rst (RST), .we (mode_we), .d (wr_data[2:0]),
        .q   (mode_sel));

    cds_cfg_reg #(.W(4), .RST_VAL(`CDS_RST_NETCFG)) u_netcfg (
        .clk (MCLK), .rst (RST), .we (cfg_we), .d (wr_data[3:0]),
        .q   (net_cfg));

    cds_cfg_reg #(.W(16), .RST_VAL(`CDS_RST_KSPD)) u_kspd (
        .clk (MCLK), .rst (RST), .we (kspd_we), .d (wr_data[15:0]),
        .q   (kp_speed));

    cds_cfg_reg #(.W(32), .RST_VAL(`CDS_RST_DPARAM)) u_dpar (
        .clk (MCLK), .rst (RST), .we (dpar_we), .d (wr_data),
        .q   (drive_param));

    // sticky write-reject flag; set wins over clear
    always_comb begin
        rej_next = rej_reg;
        if (wr_en && (reg_addr == `CDS_OFS_STATUS) &&
            wr_data[`CDS_ST_REJ]) begin
            rej_next = 1'b0;
        end
        if (dpar_hit && !dpar_we) begin
            rej_next = 1'b1;
        end
    end

    // read mux
    always_comb begin
        rd_data = 32'h0;
        case (reg_addr)
            `CDS_OFS_MODE:   rd_data = {29'h0, mode_sel};
            `CDS_OFS_NETCFG: rd_data = {28'h0, net_cfg};
            `CDS_OFS_KSPD:   rd_data = {16'h0, kp_speed};
            `CDS_OFS_DPARAM: rd_data = drive_param;
            `CDS_OFS_STATUS: rd_data = {CMD.speed, 8'h0, rej_reg,
                                        halt_reg, CMD.rev, CMD.run,
                                        1'b0, mode_reg};
            `CDS_OFS_NETCMD: rd_data = {net_reg.speed, 14'h0,
                                        net_reg.rev, net_reg.run};
            default:         rd_data = 32'h0;
        endcase
    end

    // mode that a mode-select value starts in
    function automatic cds_mode_t start_mode(input logic [2:0] sel,
                                             input logic startup);
        cds_mode_t m;
        case (sel)
            `CDS_MS_KEYPAD: m = MD_KEYPAD;
            `CDS_MS_COMB1:  m = MD_COMB1;
            `CDS_MS_COMB2:  m = MD_COMB2;
            default:        m = startup ? MD_NETWORK
                                        : MD_TERMINAL;
        endcase
        return m;
    endfunction

    // network links: lowest index wins, latch last command
    always_comb begin
        net_next = net_reg;
        req_v    = 1'b0;
        req_to   = `CDS_REQ_TERM;
        for (int i = `CDS_NET_LINKS - 1; i >= 0; i--) begin
            if (NET_MSG[i].valid) begin
                net_next.run   = NET_MSG[i].run;
                net_next.rev   = NET_MSG[i].rev;
                net_next.speed = NET_MSG[i].speed;
                req_v          = NET_MSG[i].mode_req;
                req_to         = NET_MSG[i].mode_to;
            end
        end
        if (mode_reg != MD_NETWORK) begin
            net_next.run = 1'b0;
        end
    end

    // operation mode state machine
    always_comb begin
        mode_next = mode_reg;
        if (mode_we) begin
            mode_next = start_mode(wr_data[2:0],
                                   net_cfg[`CDS_NC_STARTUP]);
        end else if (req_v) begin
            case (mode_sel)
                `CDS_MS_TERM: begin
                    if (req_to == `CDS_REQ_NET) begin
                        mode_next = MD_NETWORK;
                    end else if (req_to == `CDS_REQ_TERM) begin
                        mode_next = MD_TERMINAL;
                    end
                end
                `CDS_MS_TOGGLE, `CDS_MS_SW6, `CDS_MS_SW7: begin
                    case (req_to)
                        `CDS_REQ_NET:    mode_next = MD_NETWORK;
                        `CDS_REQ_KEYPAD: mode_next = MD_KEYPAD;
                        `CDS_REQ_TERM:   mode_next = MD_TERMINAL;
                        default:         mode_next = mode_reg;
                    endcase
                end
                default: mode_next = mode_reg;
            endcase
        end else if (KEYS.mode_toggle_key &&
                     ((mode_sel == `CDS_MS_TOGGLE) ||
                      (mode_sel == `CDS_MS_SW6) ||
                      (mode_sel == `CDS_MS_SW7))) begin
            if (mode_reg == MD_TERMINAL) begin
                mode_next = MD_KEYPAD;
            end else if (mode_reg == MD_KEYPAD) begin
                mode_next = MD_TERMINAL;
            end
        end
    end

    // keypad run latch: run/handheld_dir_keys keys start, stop key ends
    always_comb begin
        kp_run_next = kp_run_reg;
        kp_rev_next = kp_rev_reg;
        if (KEYS.fwd_key || KEYS.run_key) begin
            kp_run_next = 1'b1;
            kp_rev_next = KEYS.run_key ? kp_rev_reg : 1'b0;
        end
        if (KEYS.rev_key) begin
            kp_run_next = 1'b1;
            kp_rev_next = 1'b1;
        end
        if (KEYS.stop_key) begin
            kp_run_next = 1'b0;
        end
    end

    // terminal and combined-mode sources
    always_comb begin
        term_run = TERM.fwd_start_in ^ TERM.rev_start_in;
        term_rev = TERM.rev_start_in & ~TERM.fwd_start_in;
        if (TERM.preset_speed_inputs != 4'h0) begin
            term_spd = TSPD.preset;
        end else if (TERM.jog_in) begin
            term_spd = TSPD.jog;
        end else if (TERM.current_input_enable) begin
            term_spd = TSPD.analog_i;
        end else begin
            term_spd = TSPD.analog_v;
        end
        if (TERM.preset_speed_inputs != 4'h0) begin
            comb1_spd = TSPD.preset;
        end else if (TERM.loop_control_enable) begin
            comb1_spd = TSPD.loop;
        end else if (TERM.current_input_enable) begin
            comb1_spd = TSPD.analog_i;
        end else begin
            comb1_spd = kp_speed;
        end
    end

    // command multiplexers steered by the mode state
    always_comb begin
        src_run = term_run;
        src_rev = term_rev;
        src_spd = term_spd;
        case (mode_reg)
            MD_TERMINAL: src_spd = term_spd;
            MD_KEYPAD: begin
                src_run = kp_run_reg;
                src_rev = kp_rev_reg;
                src_spd = kp_speed;
            end
            MD_COMB1:    src_spd = comb1_spd;
            MD_COMB2: begin
                src_run = kp_run_reg;
                src_rev = kp_rev_reg;
            end
            MD_NETWORK: begin
                if (net_cfg[`CDS_NC_SPD] &&
                    !net_cfg[`CDS_NC_START]) begin
                    src_spd = net_reg.speed;
                end else if (net_cfg[`CDS_NC_START] &&
                             !net_cfg[`CDS_NC_SPD]) begin
                    src_run = net_reg.run;
                    src_rev = net_reg.rev;
                end else begin
                    src_run = net_reg.run;
                    src_rev = net_reg.rev;
                    src_spd = net_reg.speed;
                end
            end
            default: begin
                src_run = 1'b0;
            end
        endcase
    end

    // stop-key halt; release needs the run source to drop
    always_comb begin
        halt_next = halt_reg;
        if (!src_run) begin
            halt_next = 1'b0;
        end
        if (KEYS.stop_key && (net_cfg[`CDS_NC_STOPALL] ||
                              (mode_reg == MD_KEYPAD))) begin
            halt_next = 1'b1;
        end
        cmd_next.run   = src_run & ~halt_next;
        cmd_next.rev   = src_rev;
        cmd_next.speed = src_spd;
    end

    // state registers
    always_ff @(posedge MCLK) begin
        if (RST) begin
            mode_reg   <= MD_TERMINAL;
            net_reg    <= '0;
            kp_run_reg <= 1'b0;
            kp_rev_reg <= 1'b0;
            halt_reg   <= 1'b0;
            rej_reg    <= 1'b0;
            CMD        <= '0;
        end else begin
            mode_reg   <= mode_next;
            net_reg    <= net_next;
            kp_run_reg <= kp_run_next;
            kp_rev_reg <= kp_rev_next;
            halt_reg   <= halt_next;
            rej_reg    <= rej_next;
            CMD        <= cmd_next;
        end
    end

    assign MODE = mode_reg;
endmodule // cds_cmd_select

// >>> cds_cmd_checker.sv
module cds_cmd_checker (
    // clock and reset
    input wire logic               MCLK,
    input wire logic               RST,
    // bus
    input wire logic               HSEL,
    input wire logic [1:0]         HTRANS,
    input wire logic               HWRITE,
    input wire logic               HREADY,
    input wire logic               HREADYOUT,
    input wire logic               HRESP,
    // sources and command
    input wire cds_pkg::cds_term_t TERM,
    input wire cds_pkg::cds_tspd_t TSPD,
    input wire cds_pkg::cds_key_t  KEYS,
    input wire cds_pkg::cds_cmd_t  CMD,
    input wire cds_pkg::cds_mode_t MODE
);
    timeunit 1ns;
    timeprecision 1ns;
    import cds_pkg::*;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    logic go;
    // transfer taken at this edge
    assign go = HSEL & HTRANS[1] & HREADY;
    a_read_wait: assert property (go && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
    a_write_ready: assert property (go && HWRITE |=> HREADYOUT)
        else $error("write not ready");
    a_resp_okay: assert property (!HRESP)
        else $error("response not okay");
    a_mode_legal: assert property (MODE inside {[MD_TERMINAL:MD_COMB2]})
        else $error("mode state illegal");
    a_term_run: assert property ($past(MODE) == MD_TERMINAL &&
        MODE == MD_TERMINAL && CMD.run |-> CMD.rev == $past(TERM.rev_start_in)
        && $past(TERM.fwd_start_in ^ TERM.rev_start_in))
        else $error("terminal run wrong");
    a_term_preset: assert property ($past(MODE) == MD_TERMINAL &&
        MODE == MD_TERMINAL && $past(TERM.preset_speed_inputs) != 4'h0
        |-> CMD.speed == $past(TSPD.preset))
        else $error("terminal speed wrong");
    a_comb1_run: assert property ($past(MODE) == MD_COMB1 && MODE == MD_COMB1
        && CMD.run |-> $past(TERM.fwd_start_in ^ TERM.rev_start_in))
        else $error("comb1 run wrong");
    a_comb2_speed: assert property ($past(MODE) == MD_COMB2 &&
        MODE == MD_COMB2 && $past(TERM.preset_speed_inputs) != 4'h0
        |-> CMD.speed == $past(TSPD.preset))
        else $error("comb2 speed wrong");
    a_keypad_stop: assert property ($past(KEYS.stop_key) &&
        $past(MODE) == MD_KEYPAD && MODE == MD_KEYPAD |-> !CMD.run)
        else $error("stop key ignored");
    a_keypad_start: assert property ($past(MODE) == MD_KEYPAD &&
        MODE == MD_KEYPAD && $rose(CMD.run)
        |-> $past(KEYS.run_key | KEYS.fwd_key | KEYS.rev_key, 2))
        else $error("keypad run without key");
    c_read: cover property (go && !HWRITE);
    c_network: cover property (MODE == MD_NETWORK);
    c_stop: cover property ($past(KEYS.stop_key) && MODE == MD_KEYPAD);
endmodule // cds_cmd_checker

// >>> cds_net_master.sv
`include "cds_params.svh"
module cds_net_master (
    // clock
    input wire logic              clk,
    // message request
    input wire logic              go,
    input wire logic [1:0]        idx,
    input wire cds_pkg::cds_net_t msg,
    // link lines into the block
    output cds_pkg::cds_net_t     net [`CDS_NET_LINKS]
);
    timeunit 1ns;
    timeprecision 1ns;
    import cds_pkg::*;
    cds_net_t lines [`CDS_NET_LINKS] = '{default: '0};
    // one-cycle valid; while idle, valid stays low and all other fields invert every cycle
    always @(posedge clk) begin
        for (int i = 0; i < `CDS_NET_LINKS; i++) begin
            if (go && idx == i[1:0]) begin
                lines[i] <= msg;
            end else begin
                lines[i] <= {1'b0, ~lines[i][20:0]};
            end
        end
    end
    assign net = lines;
endmodule // cds_net_master

// >>> drive_command_source_select_test.sv
`include "cds_params.svh"
bind cds_cmd_select cds_cmd_checker cds_cmd_checker_inst (.MCLK(MCLK),
    .RST(RST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TERM(TERM),
    .TSPD(TSPD), .KEYS(KEYS), .CMD(CMD), .MODE(MODE));
module drive_command_source_select_test;
    timeunit 1ns;
    timeprecision 1ns;
    import cds_pkg::*;
    logic        mclk, rst, hsel, hwrite, hreadyout, hresp, nm_go;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0]  htrans, nm_idx;
    logic [2:0]  hsize;
    cds_term_t   term;
    cds_tspd_t   tspd;
    cds_key_t    keys;
    cds_net_t    net_msg [`CDS_NET_LINKS];
    cds_net_t    nm_msg;
    cds_cmd_t    cmd;
    cds_mode_t   mode;
    int          n_mismatch = 0;
    int          checks = 0;
    cds_cmd_select cds_cmd_select_inst (.MCLK(mclk), .RST(rst), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .TERM(term), .TSPD(tspd),
        .KEYS(keys), .NET_MSG(net_msg), .CMD(cmd), .MODE(mode));
    cds_net_master cds_net_master_inst (.clk(mclk), .go(nm_go),
        .idx(nm_idx), .msg(nm_msg), .net(net_msg));
    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task test_done;
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // hold the phase until hready is seen at an edge
    task wait_rdy;
        int i;
        i = 0;
        #1;
        while (hreadyout !== 1'b1) begin
            @(posedge mclk);
            #1;
            i++;
            if (i > 20) begin
                n_mismatch++;
                test_done;
            end
        end
        rv = hrdata;
        @(posedge mclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= 1'b1;
        haddr <= {24'h0, a};
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        tick(2);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        htrans <= 2'h2;
        hwrite <= 1'b0;
        haddr <= {24'h0, a};
        wait_rdy;
        htrans <= 2'h0;
        wait_rdy;
        chk(rv & m, e);
    endtask
    task key(input cds_key_t k);
        keys <= k;
        tick(1);
        keys <= '0;
        tick(2);
    endtask
    task tm(input cds_term_t v);
        term <= v;
        tick(3);
    endtask
    task net(input int i, input cds_net_t m);
        nm_go <= 1'b1;
        nm_idx <= i[1:0];
        nm_msg <= m;
        tick(1);
        nm_go <= 1'b0;
        tick(3);
    endtask
    // main sequence
    initial begin
        {rst, hsel} = 2'h3;
        {htrans, hwrite, haddr, hwdata, term, keys} = '0;
        {nm_go, nm_idx, nm_msg} = '0;
        hsize = 3'h2;
        tspd = {16'h0111, 16'h0444, 16'h0222, 16'h0321, 16'h0555};
        tick(20);
        rst <= 1'b0;
        tick(1);
        rd(`CDS_OFS_MODE, '1, 32'h0);
        rd(`CDS_OFS_NETCFG, '1, 32'h8);
        chk(mode, MD_TERMINAL);
        tm(9'h104);
        chk(cmd, {2'b10, 16'h0321});
        tm(9'h080);
        chk(cmd, {2'b11, 16'h0111});
        wr(`CDS_OFS_DPARAM, 32'h5a5a);
        rd(`CDS_OFS_DPARAM, '1, 32'h0);
        rd(`CDS_OFS_STATUS, 32'h80, 32'h80);
        key(5'h10);
        chk(mode, MD_KEYPAD);
        wr(`CDS_OFS_DPARAM, 32'h5a5a);
        rd(`CDS_OFS_DPARAM, '1, 32'h5a5a);
        key(5'h10);
        chk(mode, MD_TERMINAL);
        wr(`CDS_OFS_MODE, 32'h2);
        key(5'h10);
        chk(mode, MD_TERMINAL);
        net(0, {1'b1, 18'h0, 1'b1, `CDS_REQ_NET});
        chk(mode, MD_NETWORK);
        for (int i = 0; i < 3; i++) begin
            net(i, {3'b110, 16'h0b00 + i[15:0], 3'b000});
            chk(cmd, {2'b10, 16'h0b00 + i[15:0]});
        end
        wr(`CDS_OFS_NETCFG, 32'h9);
        chk(cmd, {2'b11, 16'h0b02});
        wr(`CDS_OFS_NETCFG, 32'ha);
        chk(cmd, {2'b10, 16'h0111});
        wr(`CDS_OFS_MODE, 32'h1);
        chk(mode, MD_KEYPAD);
        wr(`CDS_OFS_KSPD, 32'h1234);
        key(5'h04);
        chk(cmd, {2'b10, 16'h1234});
        net(1, {1'b1, 18'h0, 1'b1, `CDS_REQ_TERM});
        chk(mode, MD_KEYPAD);
        key(5'h01);
        chk(cmd.run, 1'b0);
        tm(9'h000);
        wr(`CDS_OFS_MODE, 32'h3);
        tm(9'h100);
        chk(cmd, {2'b10, 16'h1234});
        tm(9'h102);
        chk(cmd.speed, 16'h0444);
        tm(9'h103);
        chk(cmd.speed, 16'h0222);
        tm(9'h10b);
        chk(cmd.speed, 16'h0321);
        wr(`CDS_OFS_MODE, 32'h4);
        chk(cmd.run, 1'b0);
        key(5'h04);
        chk(cmd, {2'b10, 16'h0321});
        wr(`CDS_OFS_MODE, 32'h5);
        rd(`CDS_OFS_MODE, '1, 32'h4);
        rd(8'h40, '1, 32'h0);
        wr(`CDS_OFS_MODE, 32'h6);
        key(5'h10);
        chk(mode, MD_KEYPAD);
        wr(`CDS_OFS_MODE, 32'h0);
        chk(cmd.run, 1'b1);
        key(5'h01);
        chk(cmd.run, 1'b0);
        wr(`CDS_OFS_NETCFG, 32'hc);
        wr(`CDS_OFS_MODE, 32'h0);
        chk(mode, MD_NETWORK);
        wr(`CDS_OFS_STATUS, 32'h80);
        rd(`CDS_OFS_STATUS, 32'h80, 32'h0);
        test_done;
    end
endmodule // drive_command_source_select_test
